/* File: rtl/ocs_pkg.sv */
package ocs_pkg;
  localparam logic [7:0] ADDR_FRAME_SEL = 8'h59;
  localparam logic [7:0] ADDR_SLOW_SEL = 8'h5A;
  localparam logic [7:0] ADDR_DS3E3_SEL = 8'h5B;
  localparam logic [7:0] ADDR_MULT_SEL = 8'h5C;
  localparam logic [7:0] ADDR_LINE_SEL = 8'h5D;
  localparam logic [7:0] ADDR_EVT_LO = 8'h5E;
  localparam logic [7:0] ADDR_EVT_HI = 8'h5F;
  localparam logic [7:0] ADDR_MSK_LO = 8'h60;
  localparam logic [7:0] ADDR_MSK_HI = 8'h61;
  localparam logic [5:0] PW_OFF = 6'h00;
  localparam logic [5:0] PW_HALF = 6'h3F;
  localparam logic [5:0] RST_FRAME = 6'h3F;
  localparam logic [5:0] RST_SLOW = 6'h3F;
  localparam logic [1:0] RST_DS3E3 = 2'h2;
  localparam logic [3:0] RST_MULT = 4'h1;
  localparam logic [1:0] RST_LINE = 2'h2;
  localparam logic [1:0] SEL2_DS3_T1 = 2'h1;
  localparam logic [1:0] SEL2_E3_E1 = 2'h2;
  localparam logic [3:0] MULT_E1_LO = 4'h1;
  localparam logic [3:0] MULT_E1_HI = 4'h5;
  localparam logic [3:0] MULT_T1_LO = 4'h9;
  localparam logic [3:0] MULT_T1_HI = 4'hD;
  localparam int NUM_EVT = 10;
endpackage

/* File: rtl/ocs_regs.sv */
`timescale 1ns/1ps
module ocs_regs (
  input wire logic core_clk, // 125 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wr_en, // Register write strobe
  input wire logic rd_en, // Register read strobe
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata, // Read data, registered
  input wire logic [9:0] evt_in, // Event pulses, bits 0-9
  input wire logic master_osc_rate_strap, // Oscillator rate strap
  output logic osc_is_20mhz, // Captured strap
  output logic irq, // Interrupt request, active high
  output logic [5:0] frame_pulse_width, // Frame pulse width code
  output logic frame_pulse_en, // Frame pulse enabled
  output logic frame_pulse_half, // Frame pulse half duty
  output logic [5:0] slow_pulse_width, // Slow pulse width code
  output logic slow_pulse_en, // Slow pulse enabled
  output logic slow_pulse_half, // Slow pulse half duty
  output logic ds3_e3_en, // DS3/E3 output enabled
  output logic ds3_e3_is_e3, // 1 E3, 0 DS3
  output logic e1_t1_multiple_en, // Multiple output enabled
  output logic e1_t1_multiple_is_t1, // 1 T1 family, 0 E1 family
  output logic [2:0] e1_t1_multiple_shift, // Multiplier exponent 0-4
  output logic line_rate_en, // Line rate output enabled
  output logic line_rate_is_e1 // 1 E1, 0 T1
);
  logic [5:0] frame_q, frame_d, slow_q, slow_d;
  logic [1:0] ds3_q, ds3_d, line_q, line_d;
  logic [3:0] mult_q, mult_d;
  logic [9:0] evt_q, evt_d, msk_q, msk_d, clr;
  logic [7:0] rdata_q, rdata_d;
  logic strap_q, strap_d, irq_q, irq_d;

  function automatic logic sel_on(input logic [1:0] s);
    sel_on = (s == ocs_pkg::SEL2_DS3_T1) || (s == ocs_pkg::SEL2_E3_E1);
  endfunction

  always_comb begin
    frame_d = frame_q;
    slow_d = slow_q;
    ds3_d = ds3_q;
    mult_d = mult_q;
    line_d = line_q;
    msk_d = msk_q;
    clr = '0;
    if (wr_en) begin
      case (addr)
        ocs_pkg::ADDR_FRAME_SEL: frame_d = wdata[5:0];
        ocs_pkg::ADDR_SLOW_SEL: slow_d = wdata[5:0];
        ocs_pkg::ADDR_DS3E3_SEL: ds3_d = wdata[1:0];
        ocs_pkg::ADDR_MULT_SEL: mult_d = wdata[3:0];
        ocs_pkg::ADDR_LINE_SEL: line_d = wdata[1:0];
        ocs_pkg::ADDR_EVT_LO: clr[7:0] = wdata;
        ocs_pkg::ADDR_EVT_HI: clr[9:8] = wdata[1:0];
        ocs_pkg::ADDR_MSK_LO: msk_d[7:0] = wdata;
        ocs_pkg::ADDR_MSK_HI: msk_d[9:8] = wdata[1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    evt_d = (evt_q & ~clr) | evt_in;
    irq_d = |(evt_d & msk_d);
    strap_d = strap_q;
    rdata_d = rdata_q;
    if (rd_en) begin
      case (addr)
        ocs_pkg::ADDR_FRAME_SEL: rdata_d = {2'h0, frame_q};
        ocs_pkg::ADDR_SLOW_SEL: rdata_d = {2'h0, slow_q};
        ocs_pkg::ADDR_DS3E3_SEL: rdata_d = {6'h00, ds3_q};
        ocs_pkg::ADDR_MULT_SEL: rdata_d = {4'h0, mult_q};
        ocs_pkg::ADDR_LINE_SEL: rdata_d = {6'h00, line_q};
        ocs_pkg::ADDR_EVT_LO: rdata_d = evt_q[7:0];
        ocs_pkg::ADDR_EVT_HI: rdata_d = {6'h00, evt_q[9:8]};
        ocs_pkg::ADDR_MSK_LO: rdata_d = msk_q[7:0];
        ocs_pkg::ADDR_MSK_HI: rdata_d = {6'h00, msk_q[9:8]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Strap captured on the first edge after each reset release; reset clears it to 0
  logic strap_seen_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_seen_q <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      strap_seen_q <= 1'b1;
      strap_q <= strap_seen_q ? strap_d : master_osc_rate_strap;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= ocs_pkg::RST_FRAME;
      slow_q <= ocs_pkg::RST_SLOW;
      ds3_q <= ocs_pkg::RST_DS3E3;
      mult_q <= ocs_pkg::RST_MULT;
      line_q <= ocs_pkg::RST_LINE;
      evt_q <= '0;
      msk_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      frame_q <= frame_d;
      slow_q <= slow_d;
      ds3_q <= ds3_d;
      mult_q <= mult_d;
      line_q <= line_d;
      evt_q <= evt_d;
      msk_q <= msk_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  logic mult_e1, mult_t1;
  assign mult_e1 = (mult_q >= ocs_pkg::MULT_E1_LO) && (mult_q <= ocs_pkg::MULT_E1_HI);
  assign mult_t1 = (mult_q >= ocs_pkg::MULT_T1_LO) && (mult_q <= ocs_pkg::MULT_T1_HI);

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign osc_is_20mhz = strap_q;
  assign frame_pulse_width = frame_q;
  assign frame_pulse_en = frame_q != ocs_pkg::PW_OFF;
  assign frame_pulse_half = frame_q == ocs_pkg::PW_HALF;
  assign slow_pulse_width = slow_q;
  assign slow_pulse_en = slow_q != ocs_pkg::PW_OFF;
  assign slow_pulse_half = slow_q == ocs_pkg::PW_HALF;
  assign ds3_e3_en = sel_on(ds3_q);
  assign ds3_e3_is_e3 = ds3_q == ocs_pkg::SEL2_E3_E1;
  assign e1_t1_multiple_en = mult_e1 | mult_t1;
  assign e1_t1_multiple_is_t1 = mult_t1;
  assign e1_t1_multiple_shift = mult_t1 ? 3'(mult_q - ocs_pkg::MULT_T1_LO) :
                                mult_e1 ? 3'(mult_q - ocs_pkg::MULT_E1_LO) : 3'h0;
  assign line_rate_en = sel_on(line_q);
  assign line_rate_is_e1 = line_q == ocs_pkg::SEL2_E3_E1;

  property p_evt_set;
    @(posedge core_clk) disable iff (!rst_n) evt_in[0] |=> evt_q[0];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event not latched");
  property p_evt_hi;
    @(posedge core_clk) disable iff (!rst_n) evt_in[9] |=> evt_q[9];
  endproperty
  a_evt_hi: assert property (p_evt_hi) else $error("reference event not latched");
  property p_clr;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_EVT_LO && wdata[1] && !evt_in[1]) |=> !evt_q[1];
  endproperty
  a_clr: assert property (p_clr) else $error("event not cleared");
  property p_keep;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_EVT_LO && !wdata[2] && evt_q[2]) |=> evt_q[2];
  endproperty
  a_keep: assert property (p_keep) else $error("event lost on zero write");
  property p_irq;
    @(posedge core_clk) disable iff (!rst_n) irq == |(evt_q & msk_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_msk;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_MSK_HI) |=> msk_q[9:8] == $past(wdata[1:0]);
  endproperty
  a_msk: assert property (p_msk) else $error("mask write lost");
  property p_half;
    @(posedge core_clk) disable iff (!rst_n) frame_pulse_half |-> frame_pulse_en;
  endproperty
  a_half: assert property (p_half) else $error("half duty while off");
  property p_mult;
    @(posedge core_clk) disable iff (!rst_n)
      (mult_q == 4'h7 || mult_q == 4'hF) |-> !e1_t1_multiple_en;
  endproperty
  a_mult: assert property (p_mult) else $error("unlisted code enabled");
  property p_line;
    @(posedge core_clk) disable iff (!rst_n) (line_q == 2'h3) |-> !line_rate_en;
  endproperty
  a_line: assert property (p_line) else $error("line code 3 enabled");
  // Per-bit event capture, primary and secondary generators
  property p_evt_b3;
    @(posedge core_clk) disable iff (!rst_n)
      evt_in[3] |=> evt_q[3];
  endproperty
  a_evt_b3: assert property (p_evt_b3) else $error("event 3 not latched");
  property p_evt_b4;
    @(posedge core_clk) disable iff (!rst_n)
      evt_in[4] |=> evt_q[4];
  endproperty
  a_evt_b4: assert property (p_evt_b4) else $error("event 4 not latched");
  property p_evt_b7;
    @(posedge core_clk) disable iff (!rst_n)
      evt_in[7] |=> evt_q[7];
  endproperty
  a_evt_b7: assert property (p_evt_b7) else $error("event 7 not latched");
  property p_evt_b8;
    @(posedge core_clk) disable iff (!rst_n)
      evt_in[8] |=> evt_q[8];
  endproperty
  a_evt_b8: assert property (p_evt_b8) else $error("event 8 not latched");
  property p_set_wins;
    @(posedge core_clk) disable iff (!rst_n)
      (evt_in[5] && wr_en && addr == ocs_pkg::ADDR_EVT_LO && wdata[5]) |=> evt_q[5];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat new event");
  property p_evt_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (!evt_in[6] && !(wr_en && addr == ocs_pkg::ADDR_EVT_LO)) |=> evt_q[6] == $past(evt_q[6]);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event 6 changed idle");
  property p_clr_hi;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_EVT_HI && wdata[0] && !evt_in[8]) |=> !evt_q[8];
  endproperty
  a_clr_hi: assert property (p_clr_hi) else $error("event 8 not cleared");
  property p_keep_hi;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_EVT_HI && !wdata[1] && evt_q[9]) |=> evt_q[9];
  endproperty
  a_keep_hi: assert property (p_keep_hi) else $error("event 9 lost on zero write");
  // Mask and select field writes
  property p_msk_lo;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_MSK_LO) |=> msk_q[7:0] == $past(wdata);
  endproperty
  a_msk_lo: assert property (p_msk_lo) else $error("low mask write lost");
  property p_msk_keep;
    @(posedge core_clk) disable iff (!rst_n)
      !wr_en |=> msk_q == $past(msk_q);
  endproperty
  a_msk_keep: assert property (p_msk_keep) else $error("mask changed without write");
  property p_frame_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_FRAME_SEL) |=> frame_pulse_width == $past(wdata[5:0]);
  endproperty
  a_frame_wr: assert property (p_frame_wr) else $error("frame field write lost");
  property p_slow_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_en && addr == ocs_pkg::ADDR_SLOW_SEL) |=> slow_pulse_width == $past(wdata[5:0]);
  endproperty
  a_slow_wr: assert property (p_slow_wr) else $error("slow field write lost");
  property p_frame_off;
    @(posedge core_clk) disable iff (!rst_n)
      (frame_pulse_width == ocs_pkg::PW_OFF) |-> !frame_pulse_en;
  endproperty
  a_frame_off: assert property (p_frame_off) else $error("frame pulse on at code 0");
  property p_slow_half;
    @(posedge core_clk) disable iff (!rst_n)
      slow_pulse_half |-> slow_pulse_en && slow_pulse_width == ocs_pkg::PW_HALF;
  endproperty
  a_slow_half: assert property (p_slow_half) else $error("slow half duty wrong");
  // Rate selector decoding
  property p_ds3_off;
    @(posedge core_clk) disable iff (!rst_n)
      (ds3_q == 2'h0 || ds3_q == 2'h3) |-> !ds3_e3_en;
  endproperty
  a_ds3_off: assert property (p_ds3_off) else $error("ds3 output on while off");
  property p_ds3_e3;
    @(posedge core_clk) disable iff (!rst_n)
      (ds3_q == ocs_pkg::SEL2_E3_E1) |-> ds3_e3_en && ds3_e3_is_e3;
  endproperty
  a_ds3_e3: assert property (p_ds3_e3) else $error("e3 rate not selected");
  property p_ds3_ds3;
    @(posedge core_clk) disable iff (!rst_n)
      (ds3_q == ocs_pkg::SEL2_DS3_T1) |-> ds3_e3_en && !ds3_e3_is_e3;
  endproperty
  a_ds3_ds3: assert property (p_ds3_ds3) else $error("ds3 rate not selected");
  property p_mult_e1;
    @(posedge core_clk) disable iff (!rst_n)
      mult_e1 |-> e1_t1_multiple_en && !e1_t1_multiple_is_t1;
  endproperty
  a_mult_e1: assert property (p_mult_e1) else $error("e1 multiple decode wrong");
  property p_mult_t1;
    @(posedge core_clk) disable iff (!rst_n)
      mult_t1 |-> e1_t1_multiple_en && e1_t1_multiple_is_t1;
  endproperty
  a_mult_t1: assert property (p_mult_t1) else $error("t1 multiple decode wrong");
  property p_mult_gap;
    @(posedge core_clk) disable iff (!rst_n)
      (mult_q == 4'h6 || mult_q == 4'h8 || mult_q == 4'hE) |-> !e1_t1_multiple_en;
  endproperty
  a_mult_gap: assert property (p_mult_gap) else $error("gap code enabled");
  property p_line_t1;
    @(posedge core_clk) disable iff (!rst_n)
      (line_q == ocs_pkg::SEL2_DS3_T1) |-> line_rate_en && !line_rate_is_e1;
  endproperty
  a_line_t1: assert property (p_line_t1) else $error("t1 line rate not selected");
  // Enabled event must raise the request on the next edge
  property p_irq_rise;
    @(posedge core_clk) disable iff (!rst_n)
      (!wr_en && |(evt_in & msk_q)) |=> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq missed enabled event");
  c_set_clr: cover property (@(posedge core_clk) disable iff (!rst_n)
    evt_in[0] && wr_en && addr == ocs_pkg::ADDR_EVT_LO && wdata[0]);
  c_frame_off: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(frame_pulse_en));
  c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));
  c_clr: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(irq));
  c_t1: cover property (@(posedge core_clk) disable iff (!rst_n) e1_t1_multiple_is_t1);
endmodule

/* File: verif/ocs_host.sv */
`timescale 1ns/1ps
module ocs_host (
  input wire logic core_clk, // Bus clock
  input wire logic [7:0] rdata, // Read data from device
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [7:0] addr, // Address
  output logic [7:0] wdata // Write data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Released lines show inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge core_clk);
    #1;
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t value mismatch", $time); end end
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] evt_in = 10'h000;
  logic strap = 1'b0;
  logic wr_en, rd_en, irq, o20, fe, fh, se, sh, de, d3, me, mt, le, l1;
  logic [7:0] addr, wdata, rdata, v;
  logic [5:0] fw, sw;
  logic [2:0] ms;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h42E30838;
  int m [9];
  int wm [9] = '{8'h3F, 8'h3F, 8'h03, 8'h0F, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h03};
  int rv [9] = '{8'h3F, 8'h3F, 8'h02, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  always #4 core_clk = ~core_clk;
  ocs_regs ocs_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .evt_in(evt_in), .master_osc_rate_strap(strap),
    .osc_is_20mhz(o20), .irq(irq), .frame_pulse_width(fw), .frame_pulse_en(fe),
    .frame_pulse_half(fh), .slow_pulse_width(sw), .slow_pulse_en(se), .slow_pulse_half(sh),
    .ds3_e3_en(de), .ds3_e3_is_e3(d3), .e1_t1_multiple_en(me), .e1_t1_multiple_is_t1(mt),
    .e1_t1_multiple_shift(ms), .line_rate_en(le), .line_rate_is_e1(l1));
  ocs_host ocs_host_inst (.core_clk(core_clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));
  task automatic print_verdict;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk_reg(input int i);
    ocs_host_inst.rd(8'(8'h59 + i), v);
    `CHK(v, 8'(m[i]))
  endtask
  task automatic chk_dec;
    int r;
    r = m[3] inside {[1:5], [9:13]};
    `CHK({fw, fe, fh}, {6'(m[0]), m[0] != 0, m[0] == 63})
    `CHK({sw, se, sh}, {6'(m[1]), m[1] != 0, m[1] == 63})
    `CHK({de, d3}, {m[2] == 1 || m[2] == 2, m[2] == 2})
    `CHK({le, l1}, {m[4] == 1 || m[4] == 2, m[4] == 2})
    `CHK(me, 1'(r))
    if (r) `CHK({mt, ms}, {m[3] >= 9, 3'(m[3] - (m[3] >= 9 ? 9 : 1))})
    `CHK(irq, 1'(((m[5] & m[7]) | (m[6] & m[8])) != 0))
  endtask
  initial begin
    strap = 1'($random(seed));
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) m[i] = rv[i];
    @(posedge core_clk);
    #1;
    `CHK(o20, strap)
    for (int i = 0; i < 9; i++) chk_reg(i);
    chk_dec();
    for (int k = 0; k < 60; k++) begin
      int i;
      int d;
      // First sixteen passes walk every multiple code
      i = (k < 16) ? 3 : {$random(seed)} % 9;
      d = (k < 16) ? k : $random(seed) & 8'hFF;
      if (k % 3 == 0) begin
        @(posedge core_clk);
        #1;
        evt_in = 10'($random(seed));
        @(posedge core_clk);
        #1;
        m[5] |= evt_in[7:0];
        m[6] |= evt_in[9:8];
        evt_in = 10'h000;
      end
      ocs_host_inst.wr(8'(8'h59 + i), 8'(d));
      if (i == 5 || i == 6) m[i] &= ~d;
      else m[i] = d & wm[i];
      chk_reg(i);
      chk_dec();
    end
    ocs_host_inst.wr(8'h62, 8'hFF);
    ocs_host_inst.rd(8'h62, v);
    `CHK(v, 8'h00)
    for (int i = 0; i < 9; i++) chk_reg(i);
    chk_dec();
    print_verdict();
  end
endmodule
